// >>> core/adcpc_pkg.sv
// Summary of operation
// - All three power bits in one write accepted; then wait band gap time plus core settle time.
// - Sixteen analog inputs, sampled singly or in pairs, selected by software.
// - Each conversion yields a 12-bit result from a four-stage pipeline.
// - Sampling mode select 0 means sequential, 1 means simultaneous pairs.
// - Conversion starts from pwm trigger, software trigger or external start pin.
// - Sequential mode converts selected channel each sample/hold pulse, at its falling edge.
// - Sample/hold width is one plus acquisition count, bits 8 to 11, 1..16 clocks.
// - Sampling begins 2.5 converter clocks after the trigger; the sequencer raises sample/hold 4 clocks after it.
// - Sequential: first result 4 clocks after sampling, then every 2 plus count.
// - Simultaneous: A result after 4, B after 5, then every 3 plus count.
// - Simultaneous mode samples both pair channels together at pulse falling edge.
// - Interrupt flags set a few clocks after the result register update.
// - Conversion needs band gap, reference and core power all enabled.
package adcpc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADCPC_CTRL_A_OFS = 8'h00;
    localparam logic [7:0] ADCPC_CTRL_C_OFS = 8'h04;
    localparam logic [7:0] ADCPC_CHSEL_OFS = 8'h08;
    localparam logic [7:0] ADCPC_SWTRIG_OFS = 8'h0C;
    localparam logic [7:0] ADCPC_STATUS_OFS = 8'h10;
    localparam logic [7:0] ADCPC_RESULT_OFS = 8'h14;
    localparam logic [7:0] ADCPC_IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] ADCPC_IRQ_CLR_OFS = 8'h1C;
    localparam logic [7:0] ADCPC_IRQ_EN_OFS = 8'h20;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ADCPC_ACQ_LO = 8;
    localparam int ADCPC_ACQ_HI = 11;
    localparam int ADCPC_SAMPLING_MODE_SELECT_BIT = 0;
    localparam int ADCPC_CONT_BIT = 1;
    localparam int ADCPC_REF1_BIT = 7;
    localparam int ADCPC_REF0_BIT = 6;
    localparam int ADCPC_CORE_BIT = 5;
    localparam int ADCPC_RES_W = 12;
    localparam int ADCPC_CH_W = 4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ADCPC_CLK_NS = 100;
    localparam int ADCPC_BGR_MS = 5;
    localparam int ADCPC_PWD_US = 50;
    localparam int ADCPC_BGR_CYC = (ADCPC_BGR_MS * 1000000 + ADCPC_CLK_NS - 1) / ADCPC_CLK_NS;
    localparam int ADCPC_PWD_CYC = (ADCPC_PWD_US * 1000 + ADCPC_CLK_NS - 1) / ADCPC_CLK_NS;
    localparam logic [3:0] ADCPC_TRIG_HALF = 4'h5;   // 2.5 clocks in half periods
    localparam logic [4:0] ADCPC_LAT_A = 5'h04;
    localparam logic [4:0] ADCPC_LAT_B = 5'h05;
    localparam logic [4:0] ADCPC_SEQ_GAP = 5'h02;
    localparam logic [4:0] ADCPC_SIM_GAP = 5'h03;
    localparam logic [1:0] ADCPC_IRQ_DLY = 2'h2;
    typedef enum logic [2:0] {ADCPC_IDLE, ADCPC_DELAY, ADCPC_HOLD, ADCPC_WAIT} adcpc_state_e;
endpackage

// >>> core/adcpc_top.sv
`timescale 1ns/1ps
module adcpc_top
    import adcpc_pkg::*;
#(
    parameter int BGR_CYCLES = ADCPC_BGR_CYC,
    parameter int PWD_CYCLES = ADCPC_PWD_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_module_trigger,
    input wire logic external_conversion_start_pin,
    input wire logic [11:0] conv_data_a,
    input wire logic [11:0] conv_data_b,
    output logic sample_hold,
    output logic [3:0] mux_sel_a,
    output logic [3:0] mux_sel_b,
    output logic converter_clock_en,
    output logic irq
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [31:0] ctrl_a_reg, ctrl_c_reg, chsel_reg;
    logic [2:0] irq_stat_reg, irq_en_reg;
    logic [11:0] result_a_reg, result_b_reg;
    logic aw_full_reg, w_full_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [4:0] sh_len_reg;
    logic [31:0] pwr_cnt_reg;
    logic [1:0] pwm_sync_reg, pin_sync_reg;
    logic pwm_prev_reg, pin_prev_reg;
    logic sw_trig_reg;
    adcpc_state_e state_reg;
    logic [4:0] cnt_reg;
    logic [4:0] res_cnt_reg;
    logic res_pend_reg, b_pend_reg;
    logic [4:0] b_cnt_reg;
    logic [1:0] irq_dly_reg;
    logic [2:0] irq_set;
    logic [3:0] half_cnt_reg;
    logic do_write, power_ok, trigger, sample_edge, res_a_pulse, res_b_pulse;
    logic [3:0] acq;
    logic sampling_mode_select, ref_on, core_on;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign acq = ctrl_a_reg[ADCPC_ACQ_HI:ADCPC_ACQ_LO];
    assign sampling_mode_select = ctrl_a_reg[ADCPC_SAMPLING_MODE_SELECT_BIT];
    assign ref_on = ctrl_c_reg[ADCPC_REF1_BIT] & ctrl_c_reg[ADCPC_REF0_BIT];
    assign core_on = ctrl_c_reg[ADCPC_CORE_BIT];
    assign converter_clock_en = ref_on | core_on;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers; all three power bits may be written at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_reg <= 32'h0;
            ctrl_c_reg <= 32'h0;
            chsel_reg <= 32'h0;
            irq_en_reg <= 3'h0;
            sw_trig_reg <= 1'b0;
        end else begin
            sw_trig_reg <= 1'b0;
            if (do_write) begin
                unique case (awaddr_reg)
                    ADCPC_CTRL_A_OFS: ctrl_a_reg <= merge(ctrl_a_reg, wdata_reg, wstrb_reg);
                    ADCPC_CTRL_C_OFS: ctrl_c_reg <= merge(ctrl_c_reg, wdata_reg, wstrb_reg);
                    ADCPC_CHSEL_OFS: chsel_reg <= merge(chsel_reg, wdata_reg, wstrb_reg);
                    ADCPC_SWTRIG_OFS: sw_trig_reg <= wdata_reg[0] & wstrb_reg[0];
                    ADCPC_IRQ_EN_OFS: irq_en_reg <= wdata_reg[2:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr)
                ADCPC_CTRL_A_OFS: s_axi_rdata <= ctrl_a_reg;
                ADCPC_CTRL_C_OFS: s_axi_rdata <= ctrl_c_reg;
                ADCPC_CHSEL_OFS: s_axi_rdata <= chsel_reg;
                ADCPC_STATUS_OFS: s_axi_rdata <= {30'h0, state_reg != ADCPC_IDLE, power_ok};
                ADCPC_RESULT_OFS: s_axi_rdata <= {4'h0, result_b_reg, 4'h0, result_a_reg};
                ADCPC_IRQ_STAT_OFS: s_axi_rdata <= {29'h0, irq_stat_reg};
                ADCPC_IRQ_EN_OFS: s_axi_rdata <= {29'h0, irq_en_reg};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power-up wait: band gap time plus core settle time, counted from when reference and core are both on
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !(ref_on && core_on)) begin
            pwr_cnt_reg <= 32'h0;
        end else if (pwr_cnt_reg < 32'(BGR_CYCLES + PWD_CYCLES)) begin
            pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
        end
    end
    assign power_ok = ref_on && core_on && (pwr_cnt_reg >= 32'(BGR_CYCLES + PWD_CYCLES));

    // Pin and trigger synchronisers with rising edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_sync_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
            pwm_prev_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pwm_sync_reg <= {pwm_sync_reg[0], pwm_module_trigger};
            pin_sync_reg <= {pin_sync_reg[0], external_conversion_start_pin};
            pwm_prev_reg <= pwm_sync_reg[1];
            pin_prev_reg <= pin_sync_reg[1];
        end
    end
    assign trigger = power_ok && ((pwm_sync_reg[1] && !pwm_prev_reg) || (pin_sync_reg[1] && !pin_prev_reg)
        || sw_trig_reg);

    // ------------------------------------------------------------
    // Sample/hold sequencer; delay counter loaded with the half-clock constant less 3, counts whole clocks, 4 clocks to sample/hold
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ADCPC_IDLE;
            cnt_reg <= 5'h0;
            half_cnt_reg <= 4'h0;
            sample_hold <= 1'b0;
        end else begin
            unique case (state_reg)
                ADCPC_IDLE: if (trigger) begin
                    state_reg <= ADCPC_DELAY;
                    half_cnt_reg <= ADCPC_TRIG_HALF - 4'h3;
                end
                ADCPC_DELAY: if (half_cnt_reg == 4'h0) begin
                    state_reg <= ADCPC_HOLD;
                    sample_hold <= 1'b1;
                    cnt_reg <= {1'b0, acq};
                end else begin
                    half_cnt_reg <= half_cnt_reg - 4'h1;
                end
                ADCPC_HOLD: if (cnt_reg == 5'h0) begin
                    sample_hold <= 1'b0;
                    state_reg <= ctrl_a_reg[ADCPC_CONT_BIT] && power_ok ? ADCPC_WAIT : ADCPC_IDLE;
                    cnt_reg <= sampling_mode_select ? 5'h1 : 5'h0;
                end else begin
                    cnt_reg <= cnt_reg - 5'h1;
                end
                ADCPC_WAIT: if (cnt_reg == 5'h0) begin
                    state_reg <= ADCPC_HOLD;
                    sample_hold <= 1'b1;
                    cnt_reg <= {1'b0, acq};
                end else begin
                    cnt_reg <= cnt_reg - 5'h1;
                end
                default: state_reg <= ADCPC_IDLE;
            endcase
        end
    end
    assign sample_edge = (state_reg == ADCPC_HOLD) && (cnt_reg == 5'h0);

    // Channel select; pairs share index in simultaneous mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mux_sel_a <= 4'h0;
            mux_sel_b <= 4'h0;
        end else if (sampling_mode_select) begin
            mux_sel_a <= {1'b0, chsel_reg[2:0]};
            mux_sel_b <= {1'b1, chsel_reg[2:0]};
        end else begin
            mux_sel_a <= chsel_reg[ADCPC_CH_W-1:0];
            mux_sel_b <= chsel_reg[ADCPC_CH_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Result latency: A at 4 clocks after sampling, B one later
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_cnt_reg <= 5'h0;
            res_pend_reg <= 1'b0;
            b_pend_reg <= 1'b0;
            b_cnt_reg <= 5'h0;
        end else begin
            if (sample_edge) begin
                res_pend_reg <= 1'b1;
                res_cnt_reg <= ADCPC_LAT_A - 5'h1;
                b_pend_reg <= sampling_mode_select;
                b_cnt_reg <= ADCPC_LAT_B - 5'h1;
            end else begin
                if (res_pend_reg) begin
                    res_cnt_reg <= res_cnt_reg - 5'h1;
                    if (res_cnt_reg == 5'h0) begin
                        res_pend_reg <= 1'b0;
                    end
                end
                if (b_pend_reg) begin
                    b_cnt_reg <= b_cnt_reg - 5'h1;
                    if (b_cnt_reg == 5'h0) begin
                        b_pend_reg <= 1'b0;
                    end
                end
            end
        end
    end
    assign res_a_pulse = res_pend_reg && res_cnt_reg == 5'h0 && !sample_edge;
    assign res_b_pulse = b_pend_reg && b_cnt_reg == 5'h0 && !sample_edge;

    // 12-bit results from the pipelined converter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_a_reg <= 12'h000;
            result_b_reg <= 12'h000;
        end else begin
            if (res_a_pulse) begin
                result_a_reg <= conv_data_a;
            end
            if (res_b_pulse) begin
                result_b_reg <= conv_data_b;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts: flags set a few clocks after the result update
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_dly_reg <= 2'h0;
        end else if (res_a_pulse && !sampling_mode_select || res_b_pulse) begin
            irq_dly_reg <= ADCPC_IRQ_DLY;
        end else if (irq_dly_reg != 2'h0) begin
            irq_dly_reg <= irq_dly_reg - 2'h1;
        end
    end
    // Power ready event fires on the last cycle of the power-up wait
    assign irq_set = {1'b0, ref_on && core_on && pwr_cnt_reg == 32'(BGR_CYCLES + PWD_CYCLES - 1),
        irq_dly_reg == 2'h1};

    // Sticky status; set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 3'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((do_write && awaddr_reg == ADCPC_IRQ_CLR_OFS) ? wdata_reg[2:0] : 3'h0))
                | irq_set;
        end
    end
    assign irq = |(irq_stat_reg & irq_en_reg);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Helper count of sample/hold high cycles
    always_ff @(posedge aclk) begin
        if (!aresetn || !sample_hold) begin
            sh_len_reg <= 5'h0;
        end else begin
            sh_len_reg <= sh_len_reg + 5'h1;
        end
    end
    sequence hold_end_s;
        sample_edge;
    endsequence
    sequence result_a_s;
        ##4 res_a_pulse;
    endsequence
    seq_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sample_edge && !sampling_mode_select |-> result_a_s or ##4 sample_edge) else $error("A result late");
    sim_latency_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_end_s ##0 (sampling_mode_select && acq > 4'h2) |-> ##5 res_b_pulse) else $error("B result late");
    sh_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(sample_hold) |-> sh_len_reg == {1'b0, acq} + 5'h01) else $error("sample hold width");
    trig_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        trigger && state_reg == ADCPC_IDLE |-> ##4 $rose(sample_hold)) else $error("trigger delay");
    power_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !power_ok |-> !trigger) else $error("trigger before power");
    core_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
        power_ok |-> core_on && ref_on) else $error("power state");
    irq_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
        res_b_pulse && sampling_mode_select |-> ##3 irq_stat_reg[0]) else $error("flag late");
    pair_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sampling_mode_select && $stable(sampling_mode_select) && $stable(chsel_reg) |=> mux_sel_a[2:0] == mux_sel_b[2:0])
        else $error("pair mismatch");
endmodule

// >>> tb/adcpc_top_tb.sv
`timescale 1ns/1ps
module adcpc_top_tb;
    import adcpc_pkg::*;
    localparam int BGR_SIM = 20;
    localparam int PWD_SIM = 5;
    localparam int TMO_CYC = 20000;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rnd = 32'h0000_C89B, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic pwm_module_trigger = 1'b0, external_conversion_start_pin = 1'b0;
    logic [11:0] conv_data_a = 12'h000, conv_data_b = 12'h000;
    logic sample_hold, converter_clock_en, irq;
    logic [3:0] mux_sel_a, mux_sel_b;
    logic [63:0] exp_r[$];
    logic [9:0] exp_w[$];
    int error_cnt = 0, comparisons = 0, cyc = 0, sh_cnt = 0, pulses = 0;
    // ----------------------------------------------------------------
    // Clock, timeout and device
    // ----------------------------------------------------------------
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == TMO_CYC) begin
            error_cnt++;
            summarize();
        end
    end
    adcpc_top #(.BGR_CYCLES(BGR_SIM), .PWD_CYCLES(PWD_SIM)) i_adcpc_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwm_module_trigger(pwm_module_trigger),
        .external_conversion_start_pin(external_conversion_start_pin), .conv_data_a(conv_data_a),
        .conv_data_b(conv_data_b), .sample_hold(sample_hold), .mux_sel_a(mux_sel_a), .mux_sel_b(mux_sel_b),
        .converter_clock_en(converter_clock_en), .irq(irq));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (!ok) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw = 1;
            end
            if (!w && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w = 1;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    // Mask of zero marks a polling read that is not compared
    task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, output logic [31:0] d);
        exp_r.push_back({m, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic poll_status(input int b, input logic v, output int n);
        n = 0;
        do begin
            axi_read(ADCPC_STATUS_OFS, 32'h0, 32'h0, rd);
            n += 3;
        end while (rd[b] !== v && n < 600);
    endtask
    // ----------------------------------------------------------------
    // Result monitors: read data and sample/hold pulses
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        logic [63:0] e;
        if (aresetn && s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            e = exp_r.pop_front();
            if (e[63:32] != 32'h0) check((s_axi_rdata & e[63:32]) === e[31:0], "read data mismatch");
        end
    end
    always @(posedge aclk) begin
        logic [9:0] w;
        if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;
        else if (sh_cnt != 0) begin
            pulses++;
            sh_cnt <= 0;
            if (exp_w.size() == 0) check(1'b0, "unexpected sample/hold pulse");
            else begin
                w = exp_w.pop_front();
                check(sh_cnt == w[4:0], "sample/hold width");
                if (w[9]) check(mux_sel_a[2:0] === w[7:5] && mux_sel_b[2:0] === w[7:5], "pair select");
                else check(mux_sel_a === w[8:5], "channel select");
            end
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int n, lat;
        logic [3:0] acq, ch;
        logic sm;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(converter_clock_en === 1'b0 && irq === 1'b0, "outputs after reset");
        axi_read(ADCPC_STATUS_OFS, 32'hFFFF_FFFF, 32'h0, rd);
        axi_read(8'h3C, 32'hFFFF_FFFF, 32'h0, rd);
        axi_read(ADCPC_CTRL_C_OFS, 32'hFFFF_FFFF, 32'h0, rd);
        // A start before power-up must be ignored
        axi_write(ADCPC_SWTRIG_OFS, 32'h0000_0001);
        repeat (20) @(posedge aclk);
        check(pulses == 0, "conversion before power-up");
        // All three power bits in one write
        axi_write(ADCPC_CTRL_C_OFS, 32'h0000_00E0);
        axi_read(ADCPC_STATUS_OFS, 32'h0000_0001, 32'h0, rd);
        check(converter_clock_en === 1'b1, "converter clock enable");
        poll_status(0, 1'b1, n);
        check(n >= BGR_SIM && n < 600, "power-up wait");
        axi_read(ADCPC_IRQ_STAT_OFS, 32'h0000_0002, 32'h2, rd);
        axi_write(ADCPC_IRQ_CLR_OFS, 32'h0000_0002);
        axi_read(ADCPC_IRQ_STAT_OFS, 32'h0000_0002, 32'h0, rd);
        axi_write(ADCPC_IRQ_EN_OFS, 32'h0000_0001);
        // Every start source in both sampling modes, boundary counts first
        for (int k = 0; k < 7; k++) begin
            rnd = lfsr_next(rnd);
            acq = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : rnd[3:0];
            sm = (k >= 3);
            ch = sm ? {1'b0, rnd[6:4]} : rnd[7:4];
            conv_data_a <= rnd[19:8];
            conv_data_b <= rnd[31:20];
            axi_write(ADCPC_CTRL_A_OFS, {20'h0, acq, 7'h0, sm});
            axi_write(ADCPC_CHSEL_OFS, {28'h0, ch});
            exp_w.push_back({sm, ch, 5'(acq) + 5'h01});
            lat = 0;
            if (k % 3 == 0) axi_write(ADCPC_SWTRIG_OFS, 32'h0000_0001);
            else if (k % 3 == 1) pwm_module_trigger <= 1'b1;
            else external_conversion_start_pin <= 1'b1;
            while (sample_hold !== 1'b1 && lat < 50) begin
                @(posedge aclk);
                lat++;
            end
            pwm_module_trigger <= 1'b0;
            external_conversion_start_pin <= 1'b0;
            if (k % 3 != 0) check(lat >= 3 && lat <= 8, "start to sampling delay");
            else check(lat < 50, "software start");
            while (sample_hold === 1'b1) @(posedge aclk);
            n = 0;
            while (irq !== 1'b1 && n < 30) begin
                @(posedge aclk);
                n++;
            end
            check(n >= 5 && n <= 8, "result interrupt timing");
            if (sm) axi_read(ADCPC_RESULT_OFS, 32'h0FFF_0FFF, {4'h0, rnd[31:20], 4'h0, rnd[19:8]}, rd);
            else axi_read(ADCPC_RESULT_OFS, 32'h0000_0FFF, {20'h0, rnd[19:8]}, rd);
            axi_read(ADCPC_IRQ_STAT_OFS, 32'h0000_0001, 32'h1, rd);
            axi_write(ADCPC_IRQ_CLR_OFS, 32'h0000_0001);
            check(irq === 1'b0, "interrupt cleared");
            poll_status(1, 1'b0, n);
        end
        // Masked event stays sticky and raises the line once enabled
        axi_write(ADCPC_IRQ_EN_OFS, 32'h0000_0000);
        exp_w.push_back({1'b1, ch, 5'(acq) + 5'h01});
        axi_write(ADCPC_SWTRIG_OFS, 32'h0000_0001);
        repeat (40) @(posedge aclk);
        check(irq === 1'b0, "masked interrupt");
        axi_read(ADCPC_IRQ_STAT_OFS, 32'h0000_0001, 32'h1, rd);
        axi_write(ADCPC_IRQ_EN_OFS, 32'h0000_0001);
        check(irq === 1'b1 && pulses == 8, "enabled interrupt");
        summarize();
    end
endmodule
